// file: adc_ctrl_map.svh
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
// Register addresses on the core's special function register bus.
`define ADDR_FLAG_STATUS 8'hD8
`define ADDR_OPERATING_MODE 8'hD1
// Status register bit positions.
`define BIT_PRIMARY_READY 7
`define BIT_AUX_READY 6
`define BIT_CAL_DONE 5
`define BIT_MISSING_REF 4
`define BIT_PRIMARY_ERROR 3
`define BIT_AUX_ERROR 2
// Mode register bit positions.
`define BIT_PRIMARY_ENABLE 5
`define BIT_AUX_ENABLE 4
`define MODE_FIELD_MSB 2
// Reset values and writable masks.
`define RESET_FLAG_STATUS 8'h00
`define RESET_OPERATING_MODE 8'h00
`define MASK_OPERATING_MODE 8'h37
// Two filter stages after the capture stage.
`define SYNC_STAGES 3
`endif

// file: adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
   typedef enum logic [2:0] {
      MODE_POWER_DOWN,
      MODE_IDLE,
      MODE_SINGLE,
      MODE_CONTINUOUS,
      MODE_INT_ZERO_CAL,
      MODE_INT_FULL_CAL,
      MODE_SYS_ZERO_CAL,
      MODE_SYS_FULL_CAL
   } op_mode_e;
   // Completion event from one converter's modulator and filter.
   typedef struct packed {
      logic conv_done;
      logic cal_done;
      logic clamped;
      logic cal_failed;
   } conv_event_s;
   // Gated update strobes towards one converter's storage.
   typedef struct packed {
      logic result_we;
      logic coeff_we;
      logic force_ones;
   } conv_update_s;
endpackage
`default_nettype wire

// file: ref_level_sync.sv
`default_nettype none
`include "adc_ctrl_map.svh"
module ref_level_sync (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,
   // Asynchronous level in, filtered level out.
   input wire logic level_in,
   output logic level_out
);
   logic [`SYNC_STAGES-1:0] stage_q;

   // The first stage feeds only the second; a change counts once stages two and three agree.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage_q <= '0;
      end else begin
         stage_q <= {stage_q[`SYNC_STAGES-2:0], level_in};
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         level_out <= 1'b0;
      end else if (stage_q[1] == stage_q[2]) begin
         level_out <= stage_q[2];
      end
   end
endmodule
`default_nettype wire

// file: conv_update_gate.sv
`default_nettype none
module conv_update_gate
   import adc_ctrl_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,
   // Converter event and flag state.
   input wire conv_event_s evt,
   input wire logic ready_flag,
   input wire logic missing_ref,
   input wire logic ext_ref_sel,
   // Gated strobes out.
   output conv_update_s upd
);
   // Registered so the strobes line up with the flag updates in the controller.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         upd <= '0;
      end else begin
         upd.result_we <= evt.conv_done & ~ready_flag;
         upd.coeff_we <= evt.cal_done & ~evt.cal_failed & ~ready_flag;
         upd.force_ones <= missing_ref & ext_ref_sel;
      end
   end
endmodule
`default_nettype wire

// file: dual_adc_mode_status_ctrl.sv
// How it works
// - Primary ready flag, status bit 7, sets when primary conversion or calibration ends.
// - Primary ready clears on software write or on a starting mode-field write.
// - While a ready flag is set, result and coefficient writes are blocked.
// - Status bit 6 is the auxiliary ready flag, behaving like the primary one.
// - Calibration-done flag, status bit 5, sets when any calibration completes.
// - Calibration-done clears only through a mode-field write starting work.
// - Missing-reference flag, bit 4, follows reference validity while a converter runs.
// - Missing reference with external reference selected forces results to all ones.
// - Primary error flag, bit 3, sets when a primary result was clamped.
// - Primary error flag also sets when a calibration could not store coefficients.
// - Primary error flag clears when a mode-field write starts new work.
// - Status bit 2 is the auxiliary error flag, like the primary one.
// - Mode bit 5 enables the primary converter; clearing it powers it down.
// - Mode bit 4 enables the auxiliary converter; clearing it powers it down.
// - Mode bits 2 to 0 are one mode field shared by enabled converters.
// - Mode register resets to zero: both disabled, mode power-down.
// - Mode codes: down, idle, single, continuous, four calibration kinds.
// - Every mode-field write, even unchanged, resets both converters at once.
// - A finished calibration updates flags and, if it did not fail, coefficients; mode returns to 000 with the flags.
`default_nettype none
`include "adc_ctrl_map.svh"
module dual_adc_mode_status_ctrl
   import adc_ctrl_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,
   // Special function register bus.
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // Converter events and reference sensing.
   input wire conv_event_s primary_evt,
   input wire conv_event_s aux_evt,
   input wire logic reference_input_pins_bad,
   input wire logic ext_ref_sel,
   // Converter controls.
   output logic primary_enable,
   output logic aux_enable,
   output op_mode_e op_mode,
   output logic primary_reset,
   output logic aux_reset,
   output conv_update_s primary_upd,
   output conv_update_s aux_upd
);
   logic primary_ready_flag;
   logic aux_ready_flag;
   logic cal_done_flag;
   logic missing_reference_flag;
   logic primary_error_flag;
   logic aux_error_flag;
   logic ref_bad;
   logic mode_wr;
   logic stat_wr;
   logic start_work;
   logic any_active;
   logic cal_end;
   logic [7:0] stat_value;
   logic [7:0] mode_value;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode.
   assign mode_wr = sfr_wr && (sfr_addr == `ADDR_OPERATING_MODE);
   assign stat_wr = sfr_wr && (sfr_addr == `ADDR_FLAG_STATUS);
   // Any mode write other than power-down or idle starts new work.
   assign start_work = mode_wr && (sfr_wdata[`MODE_FIELD_MSB:0] > 3'h1);
   assign any_active = primary_enable | aux_enable;
   assign cal_end = (primary_evt.cal_done & primary_enable) | (aux_evt.cal_done & aux_enable);

   ref_level_sync u_ref_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .level_in(reference_input_pins_bad),
      .level_out(ref_bad)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Mode register.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         primary_enable <= 1'(`RESET_OPERATING_MODE >> `BIT_PRIMARY_ENABLE);
         aux_enable <= 1'(`RESET_OPERATING_MODE >> `BIT_AUX_ENABLE);
      end else if (mode_wr) begin
         primary_enable <= sfr_wdata[`BIT_PRIMARY_ENABLE];
         aux_enable <= sfr_wdata[`BIT_AUX_ENABLE];
      end
   end

   // A new write wins over the automatic return to power-down in the same cycle.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         op_mode <= MODE_POWER_DOWN;
      end else if (mode_wr) begin
         op_mode <= op_mode_e'(sfr_wdata[`MODE_FIELD_MSB:0]);
      end else if (cal_end && op_mode >= MODE_INT_ZERO_CAL) begin
         op_mode <= MODE_POWER_DOWN;
      end else if ((primary_evt.conv_done | aux_evt.conv_done) && op_mode == MODE_SINGLE) begin
         op_mode <= MODE_POWER_DOWN;
      end
   end

   // Converter reset pulses; a fresh primary enable also resets both.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         primary_reset <= 1'b0;
         aux_reset <= 1'b0;
      end else begin
         primary_reset <= mode_wr;
         aux_reset <= mode_wr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags. Hardware set wins over any clear in the same cycle.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         primary_ready_flag <= 1'b0;
      end else if (primary_evt.conv_done | primary_evt.cal_done) begin
         primary_ready_flag <= 1'b1;
      end else if (start_work || (stat_wr && !sfr_wdata[`BIT_PRIMARY_READY])) begin
         primary_ready_flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         aux_ready_flag <= 1'b0;
      end else if (aux_evt.conv_done | aux_evt.cal_done) begin
         aux_ready_flag <= 1'b1;
      end else if (start_work || (stat_wr && !sfr_wdata[`BIT_AUX_READY])) begin
         aux_ready_flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cal_done_flag <= 1'b0;
      end else if (primary_evt.cal_done | aux_evt.cal_done) begin
         cal_done_flag <= 1'b1;
      end else if (start_work) begin
         cal_done_flag <= 1'b0;
      end
   end

   // Holds its last value while both converters are off.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         missing_reference_flag <= 1'b0;
      end else if (any_active) begin
         missing_reference_flag <= ref_bad;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         primary_error_flag <= 1'b0;
      end else if ((primary_evt.conv_done & primary_evt.clamped)
                   | (primary_evt.cal_done & primary_evt.cal_failed)) begin
         primary_error_flag <= 1'b1;
      end else if (start_work) begin
         primary_error_flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         aux_error_flag <= 1'b0;
      end else if ((aux_evt.conv_done & aux_evt.clamped)
                   | (aux_evt.cal_done & aux_evt.cal_failed)) begin
         aux_error_flag <= 1'b1;
      end else if (start_work) begin
         aux_error_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Update gating towards result and coefficient storage.
   conv_update_gate u_primary_gate (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .evt(primary_evt),
      .ready_flag(primary_ready_flag),
      .missing_ref(missing_reference_flag),
      .ext_ref_sel(ext_ref_sel),
      .upd(primary_upd)
   );

   conv_update_gate u_aux_gate (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .evt(aux_evt),
      .ready_flag(aux_ready_flag),
      .missing_ref(missing_reference_flag),
      .ext_ref_sel(ext_ref_sel),
      .upd(aux_upd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read data, registered one cycle after the read strobe.
   assign stat_value = {primary_ready_flag, aux_ready_flag, cal_done_flag,
                        missing_reference_flag, primary_error_flag, aux_error_flag,
                        2'b00};
   assign mode_value = {2'b00, primary_enable, aux_enable, 1'b0, op_mode} & `MASK_OPERATING_MODE;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         case (sfr_addr)
            `ADDR_FLAG_STATUS: sfr_rdata <= stat_value;
            `ADDR_OPERATING_MODE: sfr_rdata <= mode_value;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: adc_ctrl_props.sv
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_ctrl_props
   import adc_ctrl_pkg::*;
(
   // Clock, reset and register bus.
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   // Converter side.
   input wire conv_event_s primary_evt,
   input wire conv_event_s aux_evt,
   input wire logic reference_input_pins_bad,
   input wire logic ext_ref_sel,
   input wire logic primary_enable,
   input wire logic aux_enable,
   input wire op_mode_e op_mode,
   input wire logic primary_reset,
   input wire logic aux_reset,
   input wire conv_update_s primary_upd,
   input wire conv_update_s aux_upd
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   wire logic mode_wr = sfr_wr && sfr_addr == `ADDR_OPERATING_MODE;
   wire logic mode_rd = sfr_rd && sfr_addr == `ADDR_OPERATING_MODE;
   wire logic stat_rd = sfr_rd && sfr_addr == `ADDR_FLAG_STATUS;
   ////////////////////////////////////////////////////////////////
   a_mode_reset: assert property (mode_wr |=> primary_reset && aux_reset)
      else $error("Converter reset pulse missing after mode write.");
   a_reset_cause: assert property ($rose(aux_reset) |-> $past(mode_wr))
      else $error("Converter reset without a mode write.");
   a_mode_fields: assert property (mode_wr |=>
      {primary_enable, aux_enable, op_mode} == $past({sfr_wdata[5:4], sfr_wdata[2:0]}))
      else $error("Mode outputs do not follow the written value.");
   a_mode_readback: assert property (mode_rd |=> sfr_rdata ==
      {2'b00, $past(primary_enable), $past(aux_enable), 1'b0, $past(op_mode)})
      else $error("Mode readback wrong.");
   a_status_rsvd: assert property (stat_rd |=> sfr_rdata[1:0] == 2'b00)
      else $error("Reserved status bits not zero.");
   a_result_cause: assert property (primary_upd.result_we |-> $past(primary_evt.conv_done))
      else $error("Primary result write without a conversion.");
   a_aux_result: assert property (aux_upd.result_we |-> $past(aux_evt.conv_done))
      else $error("Auxiliary result write without a conversion.");
   a_coeff_good: assert property (primary_upd.coeff_we |->
      $past(primary_evt.cal_done && !primary_evt.cal_failed))
      else $error("Coefficient write after a failed calibration.");
   a_force_cause: assert property (primary_upd.force_ones |-> $past(ext_ref_sel))
      else $error("All-ones forcing without external reference.");
   a_cal_returns: assert property (primary_evt.cal_done && primary_enable && !mode_wr
      && op_mode >= MODE_INT_ZERO_CAL |=> op_mode == MODE_POWER_DOWN)
      else $error("Mode field did not return to power-down.");
endmodule
bind dual_adc_mode_status_ctrl adc_ctrl_props adc_ctrl_props_inst (.*);
`default_nettype wire

// file: adc_host_model.sv
`default_nettype none
module adc_host_model (
   // Clock.
   input wire logic sys_clk,
   // Register bus towards the device.
   output logic [7:0] sfr_addr,
   output logic sfr_wr,
   output logic [7:0] sfr_wdata,
   output logic sfr_rd,
   input wire logic [7:0] sfr_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
   end
   // Data is inverted once released, so a stale value can never pass by luck.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      sfr_wr = 1'b0;
      sfr_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      #1;
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      sfr_rd = 1'b0;
      @(posedge sys_clk);
      #1;
      d = sfr_rdata;
   endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`default_nettype none
module tb_top
   import adc_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0, reset_n = 1'b0, bad_ref = 1'b0, ext_ref = 1'b0;
   logic [7:0] addr, wdata, rdata, v;
   logic wr, rd, p_en, a_en, p_rst, a_rst;
   conv_event_s p_evt = '0, a_evt = '0;
   conv_update_s p_upd, a_upd;
   op_mode_e mode;
   int bad_count = 0, samples_checked = 0, cycles = 0;
   always #20 sys_clk = ~sys_clk;
   dual_adc_mode_status_ctrl dual_adc_mode_status_ctrl_inst (.sys_clk(sys_clk),
      .reset_n(reset_n), .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wdata), .sfr_rd(rd),
      .sfr_rdata(rdata), .primary_evt(p_evt), .aux_evt(a_evt),
      .reference_input_pins_bad(bad_ref), .ext_ref_sel(ext_ref), .primary_enable(p_en),
      .aux_enable(a_en), .op_mode(mode), .primary_reset(p_rst), .aux_reset(a_rst),
      .primary_upd(p_upd), .aux_upd(a_upd));
   adc_host_model adc_host_model_inst (.sys_clk(sys_clk), .sfr_addr(addr), .sfr_wr(wr),
      .sfr_wdata(wdata), .sfr_rd(rd), .sfr_rdata(rdata));
   ////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic pulse(input logic prim, input conv_event_s e);
      @(posedge sys_clk);
      #1;
      if (prim) p_evt = e;
      else a_evt = e;
      @(posedge sys_clk);
      #1;
      p_evt = '0;
      a_evt = '0;
   endtask
   task automatic stat(input logic [7:0] exp);
      adc_host_model_inst.rd(8'hD8, v);
      check("status", v, exp);
   endtask
   task automatic t_reset;
      adc_host_model_inst.rd(8'hD1, v);
      check("mode_reset", v, 8'h00);
      stat(8'h00);
      $display("test reset done");
   endtask
   task automatic t_modes;
      for (int i = 0; i < 8; i++) begin
         adc_host_model_inst.wr(8'hD1, 8'hF8 | 8'(i));
         check("op_mode", {3'b000, p_en, a_en, mode}, 8'h18 | 8'(i));
         adc_host_model_inst.rd(8'hD1, v);
         check("mode", v, 8'h30 | 8'(i));
      end
      adc_host_model_inst.wr(8'hD1, 8'h00);
      adc_host_model_inst.rd(8'h40, v);
      check("unmapped", v, 8'h00);
      $display("test modes done");
   endtask
   task automatic t_single;
      adc_host_model_inst.wr(8'hD1, 8'h22);
      pulse(1'b1, 4'b1000);
      check("result_we", 8'(p_upd.result_we), 8'h01);
      stat(8'h80);
      // A second result while ready is still set must be held back.
      pulse(1'b1, 4'b1000);
      check("blocked_we", 8'(p_upd.result_we), 8'h00);
      adc_host_model_inst.wr(8'hD8, 8'h7F);
      stat(8'h00);
      $display("test single done");
   endtask
   task automatic t_aux_cal;
      adc_host_model_inst.wr(8'hD1, 8'h12);
      pulse(1'b0, 4'b1010);
      check("aux_we", 8'(a_upd.result_we), 8'h01);
      stat(8'h44);
      adc_host_model_inst.wr(8'hD1, 8'h34);
      stat(8'h00);
      pulse(1'b1, 4'b0101);
      check("coeff_we", 8'(p_upd.coeff_we), 8'h00);
      check("cal_mode", 8'(mode), 8'h00);
      stat(8'hA8);
      // A clean calibration with ready cleared must store its coefficients.
      adc_host_model_inst.wr(8'hD1, 8'h35);
      pulse(1'b1, 4'b0100);
      check("coeff_ok", 8'(p_upd.coeff_we), 8'h01);
      stat(8'hA0);
      $display("test calibration done");
   endtask
   task automatic t_ref;
      adc_host_model_inst.wr(8'hD1, 8'h23);
      bad_ref = 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
      // With the internal reference the flag rises but results are left alone.
      check("int_ref_force", 8'(p_upd.force_ones), 8'h00);
      ext_ref = 1'b1;
      @(posedge sys_clk);
      #1;
      check("force_ones", 8'(p_upd.force_ones), 8'h01);
      check("aux_force", 8'(a_upd.force_ones), 8'h01);
      stat(8'h10);
      bad_ref = 1'b0;
      repeat (6) @(posedge sys_clk);
      stat(8'h00);
      $display("test reference done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // The whole run needs well under a thousand cycles.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      t_reset();
      t_modes();
      t_single();
      t_aux_cal();
      t_ref();
      tally_and_finish();
   end
endmodule
`default_nettype wire
